// File: logic/ssu_defines.svh
/*
 * Register offsets, status field positions and reset values of
 * the serial unit. Assumes byte addressing on a 32-bit Avalon-MM bus.
 */
`ifndef SSU_DEFINES_SVH
`define SSU_DEFINES_SVH

`define SSU_OFF_MODE     6'h00
`define SSU_OFF_CTRL1    6'h04
`define SSU_OFF_CTRL2    6'h08
`define SSU_OFF_ENABLE   6'h0C
`define SSU_OFF_STATUS   6'h10
`define SSU_OFF_TX0      6'h20
`define SSU_OFF_RX0      6'h30

`define SSU_ST_CONFLICT  0
`define SSU_ST_OVERRUN   1
`define SSU_ST_RX_FULL   2
`define SSU_ST_TX_DONE   3
`define SSU_ST_TX_EMPTY  4

`define SSU_RST_MODE     8'h00
`define SSU_RST_CTRL1    8'h00
`define SSU_RST_CTRL2    8'h00
`define SSU_RST_ENABLE   8'h00
`define SSU_RST_STATUS   8'h18

`endif

// File: logic/ssu_pkg.sv
/*
 * Types of the serial unit: register layouts and link states.
 * Assumes ssu_defines.svh carries the numbers.
 */
`default_nettype none
package ssu_pkg;
	typedef struct packed {
		logic       bit_order_select;
		logic       clock_polarity;
		logic       clock_phase;
		logic [2:0] clock_divider;
	} ssu_mode_t;

	typedef struct packed {
		logic       data_output_select;
		logic       clock_output_select;
		logic       select_output_select;
		logic       tx_end_timing_select;
		logic       select_assert_timing;
		logic       open_drain_select;
	} ssu_ctrl2_t;

	typedef struct packed {
		logic       tx_enable;
		logic       rx_enable;
		logic       tx_end_irq_enable;
		logic       tx_empty_irq_enable;
		logic       rx_full_irq_enable;
		logic       error_irq_enable;
	} ssu_enable_t;

	typedef enum logic [3:0] {
		SSU_IDLE   = 4'b0001,
		SSU_ASSERT = 4'b0010,
		SSU_SHIFT  = 4'b0100,
		SSU_TAIL   = 4'b1000
	} ssu_state_t;
endpackage
`default_nettype wire

// File: logic/ssu_unit.sv
/*
 * One channel of the synchronous serial unit: Avalon-MM register slave on
 * i_ref_clk, link engine on i_link_clk, three interrupt lines.
 * Assumes the link clock is free running; instantiate once per channel.
 */
// Contract
// - The data length field selects how many of the four data registers of each kind are used.
// - In conflict mode the select pin is an undriven input watched for a conflict outside a transfer.
// - A clock or select pin unused by the chosen mode is left undriven for general use.
// - The channel raises an error line, a receive line and a transmit line.
`default_nettype none
`include "ssu_defines.svh"
module ssu_unit
	import ssu_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_link_clk,
	input  wire logic [5:0]  i_address,
	input  wire logic        i_read,
	input  wire logic        i_write,
	input  wire logic [31:0] i_writedata,
	input  wire logic [3:0]  i_byteenable,
	output var  logic [31:0] o_readdata,
	output var  logic        o_waitrequest,
	output var  logic        o_sck,
	output var  logic        o_sck_oe,
	output var  logic        o_mosi,
	output var  logic        o_mosi_oe,
	input  wire logic        i_miso,
	input  wire logic        i_cs_n,
	output var  logic        o_cs_n,
	output var  logic        o_cs_oe,
	output var  logic        o_error_irq,
	output var  logic        o_rx_irq,
	output var  logic        o_tx_irq
);
	// Bit position of transfer bit i in the 32-bit data word
	function automatic logic [4:0] bit_pos(input logic [4:0] i,
		input logic [1:0] len, input logic msb);
		logic [5:0] nb;
		nb = {len, 3'b000} + 6'd8;
		if (msb)
			bit_pos = 5'd31 - i;
		else
			bit_pos = 5'(6'd32 - nb + {1'b0, i});
	endfunction

	ssu_mode_t   mode;
	ssu_ctrl2_t  ctrl2;
	ssu_enable_t enable;
	logic [1:0]  data_length_select;
	logic        clock_sync_mode;
	logic [7:0]  tx_data_regs [4];
	logic [7:0]  rx_data_regs [4];
	logic        conflict_flag;
	logic        overrun_flag;
	logic        rx_full_flag;
	logic        tx_done_flag;
	logic        tx_buffer_empty_flag;
	logic        busy;
	logic        start_tgl;
	logic        done_s1, done_s2, done_s3;
	logic        conf_s1, conf_s2, conf_s3;
	logic        done_evt, conf_evt;
	logic        wr_hit, rd_hit, wr_lo;
	logic [1:0]  reg_idx;
	logic        last_tx_wr, last_rx_rd;
	logic [7:0]  status_byte;
	logic [7:0]  next_rdata;

	// Link side
	ssu_state_t  st;
	logic        lrst_s1, lrst_n;
	logic        go_s1, go_s2, go_s3;
	logic        miso_s1, miso_s;
	logic        cs_s1, cs_s;
	logic        done_tgl, conf_tgl, conf_seen;
	logic [7:0]  half_cnt;
	logic [6:0]  edge_cnt;
	logic [4:0]  bit_i;
	logic        sck_lvl;
	logic [31:0] tx_word, rx_word;
	logic        tick, lead, last_edge;
	logic [6:0]  n_edges;

	assign wr_hit = i_write & !o_waitrequest;
	assign rd_hit = i_read & o_waitrequest;
	assign wr_lo = wr_hit & i_byteenable[0];
	assign reg_idx = i_address[3:2];
	assign done_evt = done_s2 ^ done_s3;
	assign conf_evt = conf_s2 ^ conf_s3;
	assign last_tx_wr = wr_lo && i_address[5:4] == 2'b10 &&
		reg_idx == data_length_select;
	assign last_rx_rd = rd_hit && i_address[5:4] == 2'b11 &&
		reg_idx == data_length_select;
	assign status_byte = {3'b000, tx_buffer_empty_flag, tx_done_flag,
		rx_full_flag, overrun_flag, conflict_flag};

	// One wait cycle, then the answer
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n)
			o_waitrequest <= 1'b1;
		else
			o_waitrequest <= !((i_read | i_write) & o_waitrequest);
	end

	always_comb begin
		next_rdata = 8'h00;
		if (i_address == `SSU_OFF_MODE) begin
			next_rdata = {2'b00, mode};
		end else if (i_address == `SSU_OFF_CTRL1) begin
			next_rdata = {3'b000, clock_sync_mode, 2'b00, data_length_select};
		end else if (i_address == `SSU_OFF_CTRL2) begin
			next_rdata = {2'b00, ctrl2};
		end else if (i_address == `SSU_OFF_ENABLE) begin
			next_rdata = {2'b00, enable};
		end else if (i_address == `SSU_OFF_STATUS) begin
			next_rdata = status_byte;
		end else if (i_address[5:4] == 2'b10 && i_address[1:0] == 2'b00 &&
			reg_idx <= data_length_select) begin
			next_rdata = tx_data_regs[reg_idx];
		end else if (i_address[5:4] == 2'b11 && i_address[1:0] == 2'b00 &&
			reg_idx <= data_length_select) begin
			next_rdata = rx_data_regs[reg_idx];
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n)
			o_readdata <= 32'h0000_0000;
		else if (rd_hit)
			o_readdata <= {24'h00_0000, next_rdata};
	end

	// Configuration registers
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			mode <= ssu_mode_t'(`SSU_RST_MODE);
			ctrl2 <= ssu_ctrl2_t'(`SSU_RST_CTRL2);
			enable <= ssu_enable_t'(`SSU_RST_ENABLE);
			{clock_sync_mode, data_length_select} <= 3'b000;
		end else if (wr_lo) begin
			if (i_address == `SSU_OFF_MODE)
				mode <= i_writedata[5:0];
			else if (i_address == `SSU_OFF_CTRL1)
				{clock_sync_mode, data_length_select} <=
					{i_writedata[4], i_writedata[1:0]};
			else if (i_address == `SSU_OFF_CTRL2)
				ctrl2 <= i_writedata[5:0];
			else if (i_address == `SSU_OFF_ENABLE)
				enable <= i_writedata[5:0];
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (wr_lo && i_address[5:4] == 2'b10 && i_address[1:0] == 2'b00 &&
			reg_idx <= data_length_select)
			tx_data_regs[reg_idx] <= i_writedata[7:0];
	end

	// Received word is stable in the link domain once done is seen
	always_ff @(posedge i_ref_clk) begin
		if (done_evt && enable.rx_enable && !rx_full_flag)
			for (int k = 0; k < 4; k++)
				rx_data_regs[k] <= rx_word[31 - 8 * k -: 8];
	end

	// Status flags: hardware set wins over a software clear
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			{tx_buffer_empty_flag, tx_done_flag, rx_full_flag,
				overrun_flag, conflict_flag} <= 5'(`SSU_RST_STATUS);
		end else begin
			conflict_flag <= conf_evt | (conflict_flag &
				!(wr_lo && i_address == `SSU_OFF_STATUS &&
				!i_writedata[`SSU_ST_CONFLICT]));
			overrun_flag <= (done_evt & enable.rx_enable & rx_full_flag) |
				(overrun_flag & !(wr_lo && i_address == `SSU_OFF_STATUS &&
				!i_writedata[`SSU_ST_OVERRUN]));
			rx_full_flag <= (done_evt & enable.rx_enable) | (rx_full_flag &
				!last_rx_rd & !(wr_lo && i_address == `SSU_OFF_STATUS &&
				!i_writedata[`SSU_ST_RX_FULL]));
			tx_done_flag <= (done_evt & enable.tx_enable) | (tx_done_flag &
				!last_tx_wr & !(wr_lo && i_address == `SSU_OFF_STATUS &&
				!i_writedata[`SSU_ST_TX_DONE]));
			tx_buffer_empty_flag <= (done_evt & enable.tx_enable) |
				(tx_buffer_empty_flag & !last_tx_wr &
				!(wr_lo && i_address == `SSU_OFF_STATUS &&
				!i_writedata[`SSU_ST_TX_EMPTY]));
		end
	end

	// Start request and return events across the domains
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			busy <= 1'b0;
			start_tgl <= 1'b0;
		end else if (!busy && ((enable.tx_enable && !tx_buffer_empty_flag) ||
			(enable.rx_enable && !enable.tx_enable && !rx_full_flag))) begin
			busy <= 1'b1;
			start_tgl <= !start_tgl;
		end else if (done_evt) begin
			busy <= 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n)
			{done_s1, done_s2, done_s3, conf_s1, conf_s2, conf_s3} <= 6'h00;
		else
			{done_s1, done_s2, done_s3, conf_s1, conf_s2, conf_s3} <=
				{done_tgl, done_s1, done_s2, conf_tgl, conf_s1, conf_s2};
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_error_irq <= 1'b0;
			o_rx_irq <= 1'b0;
			o_tx_irq <= 1'b0;
		end else begin
			o_error_irq <= (conflict_flag | overrun_flag) &
				enable.error_irq_enable;
			o_rx_irq <= rx_full_flag & enable.rx_full_irq_enable;
			o_tx_irq <= (tx_buffer_empty_flag & enable.tx_empty_irq_enable) |
				(tx_done_flag & enable.tx_end_irq_enable);
		end
	end

	// Link domain: configuration is used unsynchronised and can be written while busy
	assign tick = half_cnt == 8'((9'd1 << mode.clock_divider) - 9'd1);
	assign lead = !edge_cnt[0];
	assign n_edges = 7'({data_length_select, 4'b0000} + 6'd15);
	assign last_edge = edge_cnt == n_edges;

	always_ff @(posedge i_link_clk) begin
		lrst_s1 <= i_rst_n;
		lrst_n <= lrst_s1;
		{go_s1, go_s2, go_s3} <= {start_tgl, go_s1, go_s2};
		{miso_s1, miso_s} <= {i_miso, miso_s1};
		{cs_s1, cs_s} <= {i_cs_n, cs_s1};
	end

	always_ff @(posedge i_link_clk) begin
		if (!lrst_n) begin
			conf_tgl <= 1'b0;
			conf_seen <= 1'b0;
		end else if (st == SSU_IDLE && !clock_sync_mode &&
			ctrl2.select_output_select) begin
			conf_seen <= !cs_s;
			if (!cs_s && !conf_seen)
				conf_tgl <= !conf_tgl;
		end else begin
			conf_seen <= 1'b0;
		end
	end

	always_ff @(posedge i_link_clk) begin
		if (!lrst_n) begin
			st <= SSU_IDLE;
			half_cnt <= 8'h00;
			edge_cnt <= 7'h00;
			bit_i <= 5'h00;
			sck_lvl <= 1'b0;
			done_tgl <= 1'b0;
			tx_word <= 32'h0000_0000;
			rx_word <= 32'h0000_0000;
			o_mosi <= 1'b1;
			o_mosi_oe <= 1'b0;
		end else begin
			half_cnt <= (st == SSU_IDLE || tick) ? 8'h00 : half_cnt + 8'h01;
			case (st)
				SSU_IDLE: begin
					edge_cnt <= 7'h00;
					bit_i <= 5'h00;
					sck_lvl <= 1'b0;
					if (go_s2 ^ go_s3) begin
						tx_word <= {tx_data_regs[0], tx_data_regs[1],
							tx_data_regs[2], tx_data_regs[3]};
						st <= SSU_ASSERT;
					end
				end
				SSU_ASSERT: begin
					if (tick) begin
						edge_cnt <= edge_cnt + 7'h01;
						if (!ctrl2.select_assert_timing || edge_cnt[0]) begin
							edge_cnt <= 7'h00;
							st <= SSU_SHIFT;
						end
					end
				end
				SSU_SHIFT: begin
					if (tick) begin
						sck_lvl <= !sck_lvl;
						edge_cnt <= edge_cnt + 7'h01;
						if (lead ^ mode.clock_phase)
							rx_word[bit_pos(bit_i, data_length_select,
								mode.bit_order_select)] <= miso_s;
						else if (!lead)
							bit_i <= bit_i + 5'h01;
						if (last_edge)
							st <= SSU_TAIL;
					end
				end
				SSU_TAIL: begin
					if (tick || !ctrl2.tx_end_timing_select) begin
						done_tgl <= !done_tgl;
						st <= SSU_IDLE;
					end
				end
				default: st <= SSU_IDLE;
			endcase
			// Open drain only pulls low
			o_mosi <= ctrl2.open_drain_select ? 1'b0 : tx_word[bit_pos(bit_i,
				data_length_select, mode.bit_order_select)];
			o_mosi_oe <= ctrl2.data_output_select && enable.tx_enable &&
				(!ctrl2.open_drain_select || !tx_word[bit_pos(bit_i,
				data_length_select, mode.bit_order_select)]);
		end
	end

	// Serial clock and select pins
	always_ff @(posedge i_link_clk) begin
		if (!lrst_n) begin
			o_sck <= 1'b0;
			o_sck_oe <= 1'b0;
			o_cs_n <= 1'b1;
			o_cs_oe <= 1'b0;
		end else begin
			o_sck <= sck_lvl ^ mode.clock_polarity;
			o_sck_oe <= ctrl2.clock_output_select;
			o_cs_n <= st == SSU_IDLE;
			o_cs_oe <= !clock_sync_mode && ctrl2.select_output_select &&
				st != SSU_IDLE;
		end
	end
endmodule
`default_nettype wire

// File: tb/ssu_unit_sva.sv
/*
 * Checker of one serial channel, watching its ports only.
 * Assumes the bus and link clocks and the synchronous reset of the unit.
 */
`default_nettype none
module ssu_unit_sva (
	input wire logic        i_ref_clk,
	input wire logic        i_rst_n,
	input wire logic        i_link_clk,
	input wire logic        i_read,
	input wire logic        i_write,
	input wire logic [31:0] o_readdata,
	input wire logic        o_waitrequest,
	input wire logic        o_sck,
	input wire logic        o_sck_oe,
	input wire logic        o_cs_n,
	input wire logic        o_cs_oe,
	input wire logic        o_error_irq,
	input wire logic        o_rx_irq,
	input wire logic        o_tx_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	answer_next_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		o_waitrequest && (i_read || i_write) |=> !o_waitrequest)
		else $error("answer late");
	answer_pulse_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		!o_waitrequest |=> o_waitrequest) else $error("answer too long");
	answer_cause_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		!o_waitrequest |-> $past(i_read || i_write)) else $error("answer unasked");
	read_upper_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		o_readdata[31:8] == 24'h00_0000) else $error("upper read bits set");
	irq_reset_a: assert property (@(posedge i_ref_clk)
		!i_rst_n |=> !(o_error_irq || o_rx_irq || o_tx_irq))
		else $error("irq during reset");
	sck_driven_a: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
		$changed(o_sck) |-> o_sck_oe || $past(o_sck_oe))
		else $error("clock moves undriven");
	cs_driven_a: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
		!o_cs_n |-> o_cs_oe) else $error("select low undriven");
	cs_hold_a: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)
		$fell(o_cs_n) |-> !o_cs_n [*8]) else $error("select too short");
endmodule
bind ssu_unit ssu_unit_sva u_ssu_unit_sva (.i_ref_clk(i_ref_clk),
	.i_rst_n(i_rst_n), .i_link_clk(i_link_clk), .i_read(i_read),
	.i_write(i_write), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
	.o_sck(o_sck), .o_sck_oe(o_sck_oe), .o_cs_n(o_cs_n), .o_cs_oe(o_cs_oe),
	.o_error_irq(o_error_irq), .o_rx_irq(o_rx_irq), .o_tx_irq(o_tx_irq));
`default_nettype wire

// File: tb/ssu_slave_model.sv
/*
 * Serial slave on the far side: shifts a reply out, captures the byte in.
 * Assumes clock polarity 0, phase 0 and one byte per frame.
 */
`default_nettype none
module ssu_slave_model (
	input  wire logic       i_sck,
	input  wire logic       i_mosi,
	input  wire logic       i_cs_n,
	output var  logic       o_miso,
	output var  logic [7:0] o_got
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] tx_shift = 8'h3C;
	always @(negedge i_cs_n) tx_shift = 8'h3C;
	always @(posedge i_sck) if (!i_cs_n) o_got = {o_got[6:0], i_mosi};
	always @(negedge i_sck) if (!i_cs_n) tx_shift = {tx_shift[6:0], 1'b0};
	// Deselected: show the inverse of the last bit
	assign o_miso = i_cs_n ? ~tx_shift[7] : tx_shift[7];
endmodule
`default_nettype wire

// File: tb/test_ssu_unit.sv
/*
 * Self-checking bench of one channel: registers, one frame, flags, conflict.
 * Assumes the slave model on the link and a pull-up on the select pin.
 */
`default_nettype none
module test_ssu_unit;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [5:0] a; logic [7:0] w; logic [7:0] r;} ssu_row_t;
	logic i_ref_clk = 0, i_link_clk = 0, i_rst_n = 0, i_read = 0, i_write = 0;
	logic [5:0] i_address = 6'h00;
	logic [31:0] i_writedata = 32'h0000_0000, o_readdata;
	logic o_waitrequest, o_sck, o_sck_oe, o_mosi, o_mosi_oe, miso, o_cs_n;
	logic o_cs_oe, o_error_irq, o_rx_irq, o_tx_irq, conflict = 0;
	logic [7:0] q, got;
	int fails = 0, checked = 0, n;
	wire cs_pin = o_cs_oe ? o_cs_n : !conflict;
	ssu_row_t rows [7] = '{'{6'h00, 8'h3F, 8'h3F}, '{6'h00, 8'h00, 8'h00},
		'{6'h04, 8'h13, 8'h13}, '{6'h04, 8'h00, 8'h00}, '{6'h08, 8'h38, 8'h38},
		'{6'h14, 8'hFF, 8'h00}, '{6'h34, 8'hFF, 8'h00}};
	ssu_unit u_ssu_unit (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
		.i_link_clk(i_link_clk), .i_address(i_address), .i_read(i_read),
		.i_write(i_write), .i_writedata(i_writedata), .i_byteenable(4'hF),
		.o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_sck(o_sck),
		.o_sck_oe(o_sck_oe), .o_mosi(o_mosi), .o_mosi_oe(o_mosi_oe),
		.i_miso(miso), .i_cs_n(cs_pin), .o_cs_n(o_cs_n), .o_cs_oe(o_cs_oe),
		.o_error_irq(o_error_irq), .o_rx_irq(o_rx_irq), .o_tx_irq(o_tx_irq));
	ssu_slave_model u_ssu_slave_model (.i_sck(o_sck), .i_mosi(o_mosi),
		.i_cs_n(cs_pin), .o_miso(miso), .o_got(got));
	initial forever #4 i_ref_clk = ~i_ref_clk;
	initial begin
		#13;
		forever #32 i_link_clk = ~i_link_clk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		i_address <= a;
		i_writedata <= {24'h00_0000, d};
		i_write <= w;
		i_read <= !w;
		do @(posedge i_ref_clk); while (o_waitrequest !== 1'b0);
		q = o_readdata[7:0];
		i_read <= 1'b0;
		i_write <= 1'b0;
	endtask
	task automatic conclude();
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic reset_check();
		i_rst_n <= 1'b0;
		repeat (4) @(posedge i_link_clk);
		@(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		for (int k = 0; k < 5; k++) begin
			bus(1'b0, 6'(k * 4), 8'h00);
			check(q, (k == 4) ? 8'h18 : 8'h00);
		end
		$display("test reset done");
	endtask
	initial begin
		#200000;
		fails++;
		conclude();
	end
	initial begin
		repeat (4) @(posedge i_link_clk);
		@(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		foreach (rows[i]) begin
			bus(1'b1, rows[i].a, rows[i].w);
			bus(1'b0, rows[i].a, 8'h00);
			check(q, rows[i].r);
		end
		$display("test registers done");
		bus(1'b1, 6'h00, 8'h02);
		bus(1'b1, 6'h0C, 8'h3F);
		repeat (3) @(posedge i_ref_clk);
		check(o_tx_irq, 1'b1);
		bus(1'b1, 6'h20, 8'hA5);
		n = 0;
		do bus(1'b0, 6'h10, 8'h00); while (!q[2] && n++ < 1000);
		check(q[3], 1'b1);
		check(o_rx_irq, 1'b1);
		check(got, 8'hA5);
		bus(1'b0, 6'h30, 8'h00);
		check(q, 8'h3C);
		repeat (3) @(posedge i_ref_clk);
		check(o_rx_irq, 1'b0);
		$display("test frame done");
		bus(1'b1, 6'h10, 8'h00);
		bus(1'b0, 6'h10, 8'h00);
		check(q, 8'h00);
		check(o_tx_irq, 1'b0);
		conflict <= 1'b1;
		for (n = 0; n < 3000 && o_error_irq !== 1'b1; n++) @(posedge i_ref_clk);
		check(o_error_irq, 1'b1);
		check(o_cs_oe, 1'b0);
		conflict <= 1'b0;
		bus(1'b0, 6'h10, 8'h00);
		check(q[0], 1'b1);
		$display("test conflict done");
		repeat (16) @(posedge i_ref_clk);
		bus(1'b1, 6'h0C, 8'h00);
		reset_check();
		conclude();
	end
endmodule
`default_nettype wire
